// [design/mrs_pkg.sv]
// Constants and carrier types for the manual reset / power switch block.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
package mrs_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int GLITCH_NS     = 100;
    // Pulses up to the glitch time ignored: need one cycle more than that
    localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS + 1;
    localparam int OFF_PRESS_MS  = 4000;
    localparam int ON_PRESS_MS   = 500;
    localparam int HOLD_1P4_US   = 1400;
    localparam int HOLD_28_MS    = 28;
    localparam int HOLD_200_MS   = 200;
    localparam int HOLD_1600_MS  = 1600;
    localparam int CYC_PER_MS    = 1000000 / CLK_PERIOD_NS;
    localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;

    localparam int CNT_W         = 26;
    localparam int FLT_W         = 4;
    localparam int NUM_CH        = 4;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic {
        MRS_MODE_PROC_RESET,
        MRS_MODE_POWER_SWITCH
    } mrs_mode_t;

    typedef enum logic [1:0] {
        MRS_HOLD_1P4MS  = 2'h0,
        MRS_HOLD_28MS   = 2'h1,
        MRS_HOLD_200MS  = 2'h2,
        MRS_HOLD_1600MS = 2'h3
    } mrs_hold_t;

    localparam mrs_hold_t MRS_HOLD_DEFAULT = MRS_HOLD_200MS;
    localparam mrs_mode_t MRS_MODE_DEFAULT = MRS_MODE_PROC_RESET;

    // Fixed configuration settings
    typedef struct packed {
        mrs_mode_t mode;
        mrs_hold_t hold_sel;
    } mrs_cfg_t;

    // Open-drain reset pin pair
    typedef struct packed {
        logic out;
        logic oe;
    } mrs_od_t;

endpackage

// [design/mrs_deglitch.sv]
// Two-stage synchroniser plus low-pulse filter for the push-button input.
// Assumes the input arrives from a pin, outside the clock domain.
`timescale 1ns/1ps
module mrs_deglitch (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic raw_in,
    output logic      filt_out
);
    import mrs_pkg::*;

    logic             sync1_reg, sync1_next;
    logic             sync2_reg, sync2_next;
    logic [FLT_W-1:0] cnt_reg,   cnt_next;
    logic             filt_reg,  filt_next;

    always_comb begin
        sync1_next = raw_in;
        sync2_next = sync1_reg;
        filt_next  = filt_reg;
        cnt_next   = '0;
        if (sync2_reg != filt_reg) begin
            cnt_next = cnt_reg + 4'h1;
            // Only a level stable past the glitch time is taken
            if (cnt_reg == FLT_W'(GLITCH_CYC - 1)) begin
                filt_next = sync2_reg; // RQ3
                cnt_next  = '0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            cnt_reg   <= '0;
            filt_reg  <= 1'b1;
        end else begin
            sync1_reg <= sync1_next; // RQ12
            sync2_reg <= sync2_next;
            cnt_reg   <= cnt_next;
            filt_reg  <= filt_next;
        end
    end

    assign filt_out = filt_reg;

    AST_GLITCH_IGNORED: assert property ( // RQ3
        @(posedge clock) disable iff (!rst_n)
        $fell(filt_reg) |-> $past(sync2_reg, 2) == 1'b0
        && $past(sync2_reg) == 1'b0)
        else $error("filtered input fell on a short pulse");

endmodule

// [design/mrs_manual_reset.sv]
// Manual reset / power on-off switch controller.
// Assumes a 10 MHz clock, synchronous reset and fuse settings held static.
// The push-button pin is weakly pulled up outside; an undriven pin reads 1.
//
// Summary of operation
// (RQ1) Two fuse-selected modes, processor reset default
// (RQ2) Unconnected manual input reads high, no action
// (RQ3) Ignore low pulses up to 100 ns
// (RQ4) Reset mode: low input asserts reset immediately
// (RQ5) After release, hold reset full hold period
// (RQ6) Switch mode: over 4 s press shuts down
// (RQ7) Standby: 500 ms press restarts enabled channels
// (RQ8) Host drops all enables to clear shutdown
// (RQ9) Hold period 1.4/28/200/1600 ms, 200 default
// (RQ10) Reset output open-drain, driven only low
// (RQ11) Logic active only with an enable high; an asserted reset ignores the enables until its hold ends
// (RQ12) Synchronise input, timers count clock cycles
// (RQ13) Press timers restart when input releases early
`timescale 1ns/1ps
module mrs_manual_reset #(
    parameter int OFF_PRESS_CYC = mrs_pkg::OFF_PRESS_MS * mrs_pkg::CYC_PER_MS,
    parameter int ON_PRESS_CYC  = mrs_pkg::ON_PRESS_MS * mrs_pkg::CYC_PER_MS,
    parameter int HOLD_0_CYC    = mrs_pkg::HOLD_1P4_US * mrs_pkg::CYC_PER_US,
    parameter int HOLD_1_CYC    = mrs_pkg::HOLD_28_MS * mrs_pkg::CYC_PER_MS,
    parameter int HOLD_2_CYC    = mrs_pkg::HOLD_200_MS * mrs_pkg::CYC_PER_MS,
    parameter int HOLD_3_CYC    = mrs_pkg::HOLD_1600_MS * mrs_pkg::CYC_PER_MS
) (
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      manual_reset_n,
    input  wire logic [mrs_pkg::NUM_CH-1:0] channel_enable,
    input  wire mrs_pkg::mrs_cfg_t         cfg,
    output logic                           reset_out_n_o,
    output logic                           reset_out_n_oe,
    output logic [mrs_pkg::NUM_CH-1:0]     channel_run,
    output logic                           ctrl_reg_clear,
    output logic                           shutdown_standby
);
    import mrs_pkg::*;

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------
    logic mr_filt;
    logic [NUM_CH-1:0] en_s1_reg, en_s2_reg;

    mrs_deglitch u_deglitch (
        .clock    (clock),
        .rst_n    (rst_n),
        .raw_in   (manual_reset_n),
        .filt_out (mr_filt)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_s1_reg <= '0;
            en_s2_reg <= '0;
        end else begin
            en_s1_reg <= channel_enable;
            en_s2_reg <= en_s1_reg;
        end
    end

    logic active;
    assign active = |en_s2_reg; // RQ11

    // ----------------------------------------------------------------
    // Control state machine
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RST_LOW,
        ST_RST_HOLD,
        ST_PRESS,
        ST_STANDBY,
        ST_WAKE
    } mrs_state_t;

    mrs_state_t        state_reg, state_next;
    logic [CNT_W-1:0]  cnt_reg,   cnt_next;
    logic              rst_reg,   rst_next;
    logic              off_reg,   off_next;
    logic              clr_reg,   clr_next;
    logic [NUM_CH-1:0] run_reg,   run_next;
    logic [CNT_W-1:0]  hold_cyc;

    always_comb begin
        case (cfg.hold_sel) // RQ9
            MRS_HOLD_1P4MS:  hold_cyc = CNT_W'(HOLD_0_CYC);
            MRS_HOLD_28MS:   hold_cyc = CNT_W'(HOLD_1_CYC);
            MRS_HOLD_1600MS: hold_cyc = CNT_W'(HOLD_3_CYC);
            default:         hold_cyc = CNT_W'(HOLD_2_CYC);
        endcase
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rst_next   = rst_reg;
        off_next   = off_reg;
        clr_next   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = '0;
                rst_next = 1'b0;
                // Pulled-up idle input stays here
                if (active && !mr_filt) begin // RQ2
                    if (cfg.mode == MRS_MODE_PROC_RESET) begin // RQ1
                        state_next = ST_RST_LOW;
                        rst_next   = 1'b1; // RQ4
                    end else begin
                        state_next = ST_PRESS;
                    end
                end
            end
            ST_RST_LOW: begin
                rst_next = 1'b1;
                cnt_next = '0;
                if (mr_filt) begin
                    state_next = ST_RST_HOLD;
                end
            end
            ST_RST_HOLD: begin
                cnt_next = cnt_reg + 26'h1;
                if (!mr_filt) begin
                    state_next = ST_RST_LOW; // RQ4
                    cnt_next   = '0;
                end else if (cnt_reg == hold_cyc - 26'h1) begin
                    state_next = ST_IDLE; // RQ5
                    rst_next   = 1'b0;
                    cnt_next   = '0;
                end
            end
            ST_PRESS: begin
                cnt_next = cnt_reg + 26'h1;
                if (mr_filt || !active) begin
                    state_next = ST_IDLE; // RQ13
                    cnt_next   = '0;
                end else if (cnt_reg == CNT_W'(OFF_PRESS_CYC)) begin
                    state_next = ST_STANDBY; // RQ6
                    off_next   = 1'b1;
                    clr_next   = 1'b1;
                    cnt_next   = '0;
                end
            end
            ST_STANDBY: begin
                cnt_next = '0;
                if (!active) begin
                    // Dropping every enable clears the shutdown
                    state_next = ST_IDLE; // RQ8
                    off_next   = 1'b0;
                end else if (mr_filt) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Wait for release first, then time a fresh press
                cnt_next = mr_filt ? '0 : cnt_reg + 26'h1; // RQ13
                if (!active) begin
                    state_next = ST_IDLE;
                    off_next   = 1'b0;
                end else if (!mr_filt && cnt_reg == CNT_W'(ON_PRESS_CYC - 1))
                begin
                    state_next = ST_IDLE; // RQ7
                    off_next   = 1'b0;
                    cnt_next   = '0;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next   = '0;
            end
        endcase
        // A restarted channel still follows its own enable
        run_next = off_next ? '0 : en_s2_reg; // RQ7
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            rst_reg   <= 1'b0;
            off_reg   <= 1'b0;
            clr_reg   <= 1'b0;
            run_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            rst_reg   <= rst_next;
            off_reg   <= off_next;
            clr_reg   <= clr_next;
            run_reg   <= run_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Pin only ever pulled low; the pull-up gives the high level
    assign reset_out_n_o    = 1'b0; // RQ10
    assign reset_out_n_oe   = rst_reg; // RQ10
    assign channel_run      = run_reg;
    assign ctrl_reg_clear   = clr_reg;
    assign shutdown_standby = off_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    AST_RST_ON_PRESS: assert property ( // RQ4
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_IDLE && active && !mr_filt
        && cfg.mode == MRS_MODE_PROC_RESET |=> reset_out_n_oe)
        else $error("reset not asserted on press");
    AST_RST_HELD_LOW: assert property ( // RQ4
        @(posedge clock) disable iff (!rst_n)
        reset_out_n_oe && !mr_filt |=> reset_out_n_oe)
        else $error("reset released while input low");
    AST_HOLD_DONE: assert property ( // RQ5
        @(posedge clock) disable iff (!rst_n)
        $fell(reset_out_n_oe) |-> $past(cnt_reg) == hold_cyc - 26'h1)
        else $error("reset released before hold period");
    AST_OD_LOW: assert property ( // RQ10
        @(posedge clock) disable iff (!rst_n)
        reset_out_n_o == 1'b0)
        else $error("open-drain pin driven high");
    AST_SHUTDOWN: assert property ( // RQ6
        @(posedge clock) disable iff (!rst_n)
        $rose(shutdown_standby) |-> ctrl_reg_clear && channel_run == '0
        && $past(cnt_reg) == CNT_W'(OFF_PRESS_CYC))
        else $error("shutdown without full long press");
    AST_WAKE: assert property ( // RQ7
        @(posedge clock) disable iff (!rst_n)
        $fell(shutdown_standby) && active |->
        $past(cnt_reg) == CNT_W'(ON_PRESS_CYC - 1))
        else $error("restart without 500 ms press");
    // Covers every state: no fresh reset may start while disabled
    AST_INACTIVE: assert property ( // RQ11
        @(posedge clock) disable iff (!rst_n)
        !active && !reset_out_n_oe |=> !reset_out_n_oe)
        else $error("reset asserted with no enable");
    AST_PRESS_RESTART: assert property ( // RQ13
        @(posedge clock) disable iff (!rst_n)
        state_reg == ST_PRESS && mr_filt |=> cnt_reg == '0)
        else $error("press timer not restarted");
    AST_MODE_SWITCH: assert property ( // RQ1
        @(posedge clock) disable iff (!rst_n)
        cfg.mode == MRS_MODE_POWER_SWITCH && $stable(cfg) |=>
        !$rose(reset_out_n_oe))
        else $error("reset asserted in switch mode");

    COV_PROC_RESET: cover property (@(posedge clock) disable iff (!rst_n)
        $fell(reset_out_n_oe));
    COV_SHUTDOWN: cover property (@(posedge clock) disable iff (!rst_n)
        $rose(shutdown_standby));
    COV_RESTART: cover property (@(posedge clock) disable iff (!rst_n)
        $fell(shutdown_standby) && active);
    COV_ABORT_PRESS: cover property (@(posedge clock) disable iff (!rst_n)
        state_reg == ST_PRESS && mr_filt);

endmodule

// [sim/mrs_button_model.sv]
// Push-button on the manual reset pin and the processor reset input.
// Assumes the bench closes the switch through press; pull-ups are ideal.
`timescale 1ns/1ps
module mrs_button_model (
    input  wire logic press,
    input  wire logic rst_drv_o,
    input  wire logic rst_drv_oe,
    output logic      manual_reset_n,
    output logic      reset_pin
);
    // Open switch leaves the pin on its pull-up
    assign manual_reset_n = press ? 1'b0 : 1'b1;
    // Open-drain line: pull-up wins unless the device pulls low
    assign reset_pin = rst_drv_oe ? rst_drv_o : 1'b1;
endmodule

// [sim/tb.sv]
// Self-checking bench for the manual reset / power switch controller.
// Assumes shortened press and hold counts; filter latency of a few cycles.
`timescale 1ns/1ps
module tb;
    import mrs_pkg::*;
    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam int OFF_C = 200;
    localparam int ON_C  = 50;
    logic              clock          = 1'b0;
    logic              rst_n          = 1'b0;
    logic              press          = 1'b0;
    logic [NUM_CH-1:0] channel_enable = '0;
    mrs_cfg_t          cfg            = '{MRS_MODE_DEFAULT, MRS_HOLD_DEFAULT};
    wire               manual_reset_n;
    wire               reset_pin;
    logic              o;
    logic              oe;
    logic              clr;
    logic              stby;
    logic [NUM_CH-1:0] run;
    int                miscompares    = 0;
    int                check_count    = 0;
    int                seed           = 30;
    int                bad;
    int                hold_tab[4]    = '{20, 30, 40, 50};

    always #50 clock = ~clock;

    mrs_manual_reset #(.OFF_PRESS_CYC(OFF_C), .ON_PRESS_CYC(ON_C),
        .HOLD_0_CYC(20), .HOLD_1_CYC(30), .HOLD_2_CYC(40),
        .HOLD_3_CYC(50)) dut_u (
        .clock(clock), .rst_n(rst_n), .manual_reset_n(manual_reset_n),
        .channel_enable(channel_enable), .cfg(cfg), .reset_out_n_o(o),
        .reset_out_n_oe(oe), .channel_run(run), .ctrl_reg_clear(clr),
        .shutdown_standby(stby));
    mrs_button_model bm_u (.press(press), .rst_drv_o(o), .rst_drv_oe(oe),
        .manual_reset_n(manual_reset_n), .reset_pin(reset_pin));

    // ----------------------------------------------------------------
    // Checks and drivers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [3:0] e,
                       input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Tolerance covers the sync and filter latency only
    task automatic chk_n(input string nm, input int e, input int g,
                         input int tol);
        check_count++;
        if (g < e - tol || g > e + tol) begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic proc_cycle(input int sel, input int len, input bit again);
        int lat;
        int n;
        int nb;
        @(posedge clock);
        cfg.hold_sel <= mrs_hold_t'(sel);
        @(posedge clock);
        press <= 1'b1;
        lat = 0;
        nb = 0;
        do begin
            @(negedge clock);
            lat++;
        end while (oe !== 1'b1 && lat < 20);
        chk_n("assert_latency", 5, lat, 2);
        repeat (len) begin
            @(negedge clock);
            if (oe !== 1'b1 || reset_pin !== 1'b0) nb++;
        end
        chk_n("held_low", 0, nb, 0);
        @(posedge clock);
        if (again) begin
            press <= 1'b0;
            repeat (hold_tab[sel] / 2) @(negedge clock);
            chk("rearm_oe", 4'h1, oe);
            @(posedge clock);
            press <= 1'b1;
            repeat (10) @(posedge clock);
        end
        press <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (oe === 1'b1 && n < 100);
        chk_n("hold_cycles", lat + hold_tab[sel], n, 2);
        chk("pin_released", 4'h1, reset_pin);
    endtask
    task automatic sw_press(input logic lvl, input int e, input int p);
        int n;
        int pulses;
        int rst_seen;
        @(posedge clock);
        press <= 1'b1;
        n = 0;
        pulses = 0;
        rst_seen = 0;
        do begin
            @(negedge clock);
            n++;
            if (clr === 1'b1) pulses++;
            if (oe !== 1'b0) rst_seen++;
        end while (stby !== lvl && n < e + 50);
        repeat (5) begin
            @(negedge clock);
            if (clr === 1'b1) pulses++;
            if (oe !== 1'b0) rst_seen++;
        end
        @(posedge clock);
        press <= 1'b0;
        chk_n("press_cycles", e, n, 3);
        chk_n("clear_pulses", p, pulses, 0);
        chk_n("switch_oe", 0, rst_seen, 0);
    endtask

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        channel_enable <= 4'hF;
        repeat (10) @(negedge clock);
        chk("idle_oe", 4'h0, oe);
        chk("run_on", 4'hF, run);
        end_test("idle");
        bad = 0;
        repeat (8) begin
            @(posedge clock);
            press <= 1'b1;
            @(posedge clock);
            press <= 1'b0;
            repeat (6 + ($random(seed) & 7)) begin
                @(negedge clock);
                if (oe !== 1'b0) bad++;
            end
        end
        chk_n("glitch_oe", 0, bad, 0);
        end_test("glitch");
        proc_cycle(2, 10 + ($random(seed) & 15), 1'b0);
        for (int s = 0; s < 4; s++) begin
            proc_cycle(s, 10 + ($random(seed) & 15), s == 1);
        end
        end_test("proc_reset");
        @(posedge clock);
        channel_enable <= 4'h0;
        repeat (5) @(posedge clock);
        press <= 1'b1;
        bad = 0;
        repeat (30) begin
            @(negedge clock);
            if (oe !== 1'b0) bad++;
        end
        chk_n("disabled_oe", 0, bad, 0);
        chk("disabled_run", 4'h0, run);
        @(posedge clock);
        press <= 1'b0;
        channel_enable <= 4'hF;
        cfg.mode <= MRS_MODE_POWER_SWITCH;
        end_test("disabled");
        repeat (60) @(posedge clock);
        press <= 1'b1;
        repeat (150) @(posedge clock);
        press <= 1'b0;
        repeat (10) @(negedge clock);
        chk("early_release", 4'h0, stby);
        sw_press(1'b1, OFF_C + 6, 1);
        chk("off_run", 4'h0, run);
        @(posedge clock);
        channel_enable <= 4'h5;
        repeat (10) @(posedge clock);
        press <= 1'b1;
        repeat (30) @(posedge clock);
        press <= 1'b0;
        repeat (10) @(negedge clock);
        chk("short_wake", 4'h1, stby);
        sw_press(1'b0, ON_C + 6, 0);
        repeat (5) @(negedge clock);
        chk("wake_run", 4'h5, run);
        sw_press(1'b1, OFF_C + 6, 1);
        @(posedge clock);
        channel_enable <= 4'h0;
        repeat (10) @(negedge clock);
        chk("enables_clear", 4'h0, stby);
        end_test("power_switch");
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        close_out();
    end
endmodule
